/* File: otp_programmer.sv */
// Programmer end: takes orders through a small register file and runs
// the pin sequences for program, verify and signature read.
// Assumes the device samples the link pins through its own synchroniser.
//
// The address map and the strobed register port were left to the implementer.
`include "otp_port_consts.svh"
module otp_programmer #(
  parameter int ADDR_W = 13,
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Link
  otp_link_if.programmer link
);
  import otp_port_pkg::*;

  prog_state_e state;
  prog_op_e op;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] rdata_reg;
  logic busy, done;
  logic [CNT_W-1:0] cnt;
  logic [4:0] pulses;
  logic [1:0] osc_div;
  logic [7:0] data_meta, data_sync;
  logic start, cnt_done, is_prog;

  function automatic logic [4:0] mode_of(input prog_op_e o);
    case (o)
      op_code: mode_of = `MODE_CODE;
      op_enc: mode_of = `MODE_ENC;
      op_lock1: mode_of = `MODE_LOCK1;
      op_lock2: mode_of = `MODE_LOCK2;
      op_lock3: mode_of = `MODE_LOCK3;
      op_verify: mode_of = `MODE_VERIFY;
      default: mode_of = `MODE_SIG;
    endcase
  endfunction

  function automatic logic [4:0] pulses_of(input prog_op_e o);
    pulses_of = (o == op_code) ? 5'(`CODE_PULSES) : 5'(`LONG_PULSES);
  endfunction

  assign start = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_START] && !busy;
  assign cnt_done = cnt == '0;
  assign is_prog = op != op_verify && op != op_sig;

  // Oscillator out, 5 MHz from ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_div <= '0;
      link.osc_clk <= 1'b0;
    end else begin
      if (osc_div == 2'(`OSC_DIV - 1)) begin
        osc_div <= '0;
        link.osc_clk <= !link.osc_clk;
      end else begin
        osc_div <= osc_div + 2'h1;
      end
    end
  end

  // Read-back data synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_meta <= 8'hff;
      data_sync <= 8'hff;
    end else begin
      data_meta <= link.data_port;
      data_sync <= data_meta;
    end
  end

  // Order registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      op <= op_code;
      addr_reg <= '0;
      data_reg <= 8'hff;
    end else if (reg_wr && !busy) begin
      if (reg_addr == `REG_CTRL) op <= prog_op_e'(reg_wdata[2:0]);
      if (reg_addr == `REG_ADDR) addr_reg <= reg_wdata[ADDR_W-1:0];
      if (reg_addr == `REG_DATA) data_reg <= reg_wdata[7:0];
    end
  end

  // Register read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {13'h0000, op};
        `REG_ADDR: reg_rdata <= {3'h0, addr_reg};
        `REG_DATA: reg_rdata <= {8'h00, data_reg};
        `REG_STATUS: reg_rdata <= {14'h0000, done, busy};
        `REG_RDATA: reg_rdata <= {8'h00, rdata_reg};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      cnt <= '0;
      pulses <= '0;
    end else begin
      case (state)
        st_idle: if (start) state <= st_addr;
        st_addr: state <= st_mode;
        st_mode: begin
          cnt <= CNT_W'(`SETUP_CYC);
          state <= st_setup;
        end
        st_setup: begin
          if (!cnt_done) begin
            cnt <= cnt - 1'b1;
          end else if (is_prog) begin
            cnt <= CNT_W'(`VPP_CYC);
            pulses <= pulses_of(op);
            state <= st_raise;
          end else begin
            state <= st_read;
          end
        end
        st_raise: begin
          if (!cnt_done) begin
            cnt <= cnt - 1'b1;
          end else begin
            cnt <= CNT_W'(`PULSE_CYC);
            state <= st_pulse;
          end
        end
        st_pulse: begin
          if (!cnt_done) begin
            cnt <= cnt - 1'b1;
          end else begin
            cnt <= CNT_W'(`GAP_CYC);
            pulses <= pulses - 5'h01;
            state <= st_gap;
          end
        end
        st_gap: begin
          if (!cnt_done) begin
            cnt <= cnt - 1'b1;
          end else if (pulses != '0) begin
            cnt <= CNT_W'(`PULSE_CYC);
            state <= st_pulse;
          end else begin
            cnt <= CNT_W'(`SETUP_CYC);
            state <= st_lower;
          end
        end
        st_lower: begin
          if (!cnt_done) cnt <= cnt - 1'b1;
          else state <= st_release;
        end
        st_read: state <= st_release;
        st_release: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // Status and captured read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      if (start) busy <= 1'b1;
      else if (state == st_release) busy <= 1'b0;
      if (state == st_release) done <= 1'b1;
      else if (start) done <= 1'b0;
      if (state == st_read) rdata_reg <= data_sync;
    end
  end

  // Address, data and mode pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.low_address_port <= '0;
      link.high_address_port <= '0;
      link.prog_data <= 8'hff;
      link.prog_data_oe_n <= 1'b1;
      {link.mode_select_a, link.mode_select_b, link.mode_select_c, link.mode_select_d,
       link.mode_select_e} <= `MODE_SIG;
      link.reset_pin <= 1'b1;
      link.fetch_strobe <= 1'b1;
    end else begin
      case (state)
        st_addr: begin
          {link.high_address_port, link.low_address_port} <= addr_reg;
          link.prog_data <= data_reg;
          link.prog_data_oe_n <= !is_prog;
        end
        st_mode: begin
          {link.mode_select_a, link.mode_select_b, link.mode_select_c, link.mode_select_d,
           link.mode_select_e} <= mode_of(op);
          link.reset_pin <= 1'b0;
          link.fetch_strobe <= op == op_sig;
        end
        st_release: begin
          link.prog_data_oe_n <= 1'b1;
          {link.mode_select_a, link.mode_select_b, link.mode_select_c, link.mode_select_d,
           link.mode_select_e} <= `MODE_SIG;
          link.reset_pin <= 1'b1;
          link.fetch_strobe <= 1'b1;
        end
        default: link.reset_pin <= link.reset_pin;
      endcase
    end
  end

  // Supply and strobe pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.supply_level <= 1'b1;
      link.supply_vpp <= 1'b0;
      link.program_strobe <= 1'b1;
    end else begin
      link.supply_level <= 1'b1;
      link.supply_vpp <= state == st_raise || state == st_pulse || state == st_gap;
      link.program_strobe <= state != st_pulse;
    end
  end
endmodule // otp_programmer

/* File: otp_port_consts.svh */
// Constants for the one-time-programmable code memory port.
// Assumes a 20 MHz ref_clk on both ends of the link.
// Functional notes
// - Programmer supplies 4 to 6 MHz oscillator
// - Address: low port plus five high bits
// - Code program: strobe pulses at 12.75V
// - Verify levels; device drives addressed byte
// - Encryption bytes: like code, select D low
// - Lock bits: own mode combinations, pulsed
// - Order: address, data, modes, voltage, pulses
// - Five pulses per code byte, else 25
// - Supply high; raised only around pulses
// - Sequence repeated per byte
// - 64-byte encryption array reads ones initially; verify here indexes only bytes 0 to 31 (address bits 4:0)
// - Verify output XNOR with encryption byte
// - Fill unused code with varied non-FF values
// - Lock bits not readable directly
// - No locks: verify still scrambled
// - Lock one: table reads blocked, programming refused
// - Lock two adds verify disable
// - Lock three blocks external execution
// - Only four lock combinations used
// - Signature bytes at 30H, 31H, 60H
// - Signature read levels: all selects low
`ifndef OTP_PORT_CONSTS_SVH
`define OTP_PORT_CONSTS_SVH
`define REF_CLK_MHZ 20
`define T_PULSE_US 100
`define T_GAP_US 10
`define T_VPP_US 10
`define T_SETUP_NS 12000
`define PULSE_CYC (`T_PULSE_US * `REF_CLK_MHZ)
`define GAP_CYC (`T_GAP_US * `REF_CLK_MHZ)
`define VPP_CYC (`T_VPP_US * `REF_CLK_MHZ)
`define SETUP_CYC ((`T_SETUP_NS * `REF_CLK_MHZ + 999) / 1000)
`define OSC_DIV 2
`define OSC_LIVE_CYC 16
`define CODE_PULSES 5
`define LONG_PULSES 25
`define MODE_CODE 5'h0f
`define MODE_VERIFY 5'h03
`define MODE_ENC 5'h0d
`define MODE_LOCK1 5'h1f
`define MODE_LOCK2 5'h1c
`define MODE_LOCK3 5'h16
`define MODE_SIG 5'h00
`define SIG_LOC0 8'h30
`define SIG_LOC1 8'h31
`define SIG_LOC2 8'h60
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0c
`define REG_RDATA 8'h10
`define CTRL_START 7
`define ENC_SEL_BITS 5
`endif

/* File: otp_port_pkg.sv */
// Types shared by both ends of the programming link.
// Assumes otp_port_consts.svh for numeric constants.
package otp_port_pkg;
  typedef enum logic [2:0] {
    op_code, op_enc, op_lock1, op_lock2, op_lock3, op_verify, op_sig
  } prog_op_e;
  typedef enum logic [3:0] {
    st_idle, st_addr, st_mode, st_setup, st_raise, st_pulse, st_gap, st_lower, st_read, st_release
  } prog_state_e;
  typedef struct packed {
    logic osc;
    logic reset_pin;
    logic fetch_strobe;
    logic program_strobe;
    logic supply_level;
    logic supply_vpp;
    logic [4:0] modes;
    logic [4:0] high_address;
    logic [7:0] low_address;
    logic [7:0] data;
  } link_pins_s;
endpackage

/* File: otp_link_if.sv */
// Programming link between the external programmer and the device.
// The data port wire level is resolved here from both enables.
interface otp_link_if;
  logic osc_clk;
  logic reset_pin;
  logic fetch_strobe;
  logic program_strobe;
  logic supply_level;
  logic supply_vpp;
  logic mode_select_a;
  logic mode_select_b;
  logic mode_select_c;
  logic mode_select_d;
  logic mode_select_e;
  logic [7:0] low_address_port;
  logic [4:0] high_address_port;
  logic [7:0] prog_data;
  logic prog_data_oe_n;
  logic [7:0] dev_data;
  logic dev_data_oe_n;
  logic [7:0] data_port;
  assign data_port = !prog_data_oe_n ? prog_data : (!dev_data_oe_n ? dev_data : 8'hff);
  modport programmer (
    output osc_clk, reset_pin, fetch_strobe, program_strobe, supply_level, supply_vpp,
    output mode_select_a, mode_select_b, mode_select_c, mode_select_d, mode_select_e,
    output low_address_port, high_address_port, prog_data, prog_data_oe_n,
    input data_port
  );
  modport device (
    input osc_clk, reset_pin, fetch_strobe, program_strobe, supply_level, supply_vpp,
    input mode_select_a, mode_select_b, mode_select_c, mode_select_d, mode_select_e,
    input low_address_port, high_address_port, data_port,
    output dev_data, dev_data_oe_n
  );
endinterface

/* File: otp_device.sv */
// Device end: code memory, encryption array, lock bits and signature.
// Assumes link pins come from another chip; all pass two flip-flops.
`include "otp_port_consts.svh"
module otp_device #(
  parameter int ADDR_W = 13,
  parameter logic [7:0] SIG_BYTE0 = 8'h11, // Arbitrary value
  parameter logic [7:0] SIG_BYTE1 = 8'h22, // Arbitrary value
  parameter logic [7:0] SIG_BYTE2 = 8'h33  // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  otp_link_if.device link,
  // Protection status to the core
  output logic table_read_blocked,
  output logic ext_exec_blocked,
  output logic ext_access_latched
);
  import otp_port_pkg::*;

  link_pins_s raw, meta, pins;
  logic prev_strobe, prev_osc, osc_alive;
  logic [4:0] osc_cnt;
  logic lock_bit_one, lock_bit_two, lock_bit_three;
  logic [7:0] code_mem [0:(1 << ADDR_W) - 1];
  logic [(1 << ADDR_W) - 1:0] written;
  logic [7:0] enc_mem [0:63];
  logic [ADDR_W-1:0] addr;
  logic prog_edge, prog_ok, verify_sel, sig_sel;
  logic [7:0] code_byte;

  function automatic logic [7:0] sig_lookup(input logic [7:0] loc);
    case (loc)
      `SIG_LOC0: sig_lookup = SIG_BYTE0;
      `SIG_LOC1: sig_lookup = SIG_BYTE1;
      `SIG_LOC2: sig_lookup = SIG_BYTE2;
      default: sig_lookup = 8'h00;
    endcase
  endfunction

  assign raw = '{osc: link.osc_clk, reset_pin: link.reset_pin, fetch_strobe: link.fetch_strobe,
                 program_strobe: link.program_strobe, supply_level: link.supply_level,
                 supply_vpp: link.supply_vpp,
                 modes: {link.mode_select_a, link.mode_select_b, link.mode_select_c,
                         link.mode_select_d, link.mode_select_e},
                 high_address: link.high_address_port, low_address: link.low_address_port,
                 data: link.data_port};

  // Two-stage input synchroniser, reset to the idle pin levels except data, which resets to 00 rather than the idle ff
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '{reset_pin: 1'b1, fetch_strobe: 1'b1, program_strobe: 1'b1, supply_level: 1'b1, default: '0};
      pins <= '{reset_pin: 1'b1, fetch_strobe: 1'b1, program_strobe: 1'b1, supply_level: 1'b1, default: '0};
    end else begin
      meta <= raw;
      pins <= meta;
    end
  end

  assign addr = {pins.high_address, pins.low_address};
  assign code_byte = written[addr] ? code_mem[addr] : 8'hff;
  assign prog_edge = prev_strobe && !pins.program_strobe;
  assign prog_ok = prog_edge && pins.supply_vpp && !pins.reset_pin && !pins.fetch_strobe && osc_alive;
  assign verify_sel = !pins.reset_pin && !pins.fetch_strobe && pins.program_strobe && pins.supply_level
                      && !pins.supply_vpp && pins.modes == `MODE_VERIFY;
  assign sig_sel = !pins.reset_pin && pins.fetch_strobe && pins.program_strobe && pins.supply_level
                   && !pins.supply_vpp && pins.modes == `MODE_SIG;

  // Oscillator presence check
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_osc <= 1'b0;
      osc_cnt <= '0;
      osc_alive <= 1'b0;
    end else begin
      prev_osc <= pins.osc;
      if (prev_osc != pins.osc) begin
        osc_cnt <= '0;
        osc_alive <= 1'b1;
      end else if (osc_cnt == 5'(`OSC_LIVE_CYC)) begin
        osc_alive <= 1'b0;
      end else begin
        osc_cnt <= osc_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) prev_strobe <= 1'b1;
    else prev_strobe <= pins.program_strobe;
  end

  // Code array; programming only clears bits; rst_n makes every byte read ff again
  always_ff @(posedge ref_clk) begin
    if (prog_ok && !lock_bit_one && pins.modes == `MODE_CODE) code_mem[addr] <= code_byte & pins.data;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) written <= '0;
    else if (prog_ok && !lock_bit_one && pins.modes == `MODE_CODE) written[addr] <= 1'b1;
  end

  // Encryption array, all ones until programmed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) enc_mem[i] <= 8'hff;
    end else if (prog_ok && !lock_bit_one && pins.modes == `MODE_ENC) begin
      enc_mem[addr[5:0]] <= enc_mem[addr[5:0]] & pins.data;
    end
  end

  // Lock bits, visible only through their effects
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_bit_one <= 1'b0;
      lock_bit_two <= 1'b0;
      lock_bit_three <= 1'b0;
    end else if (prog_ok) begin
      if (pins.modes == `MODE_LOCK1) lock_bit_one <= 1'b1;
      if (pins.modes == `MODE_LOCK2) lock_bit_two <= 1'b1;
      if (pins.modes == `MODE_LOCK3) lock_bit_three <= 1'b1;
    end
  end

  // Verify and signature read-back
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.dev_data <= 8'hff;
      link.dev_data_oe_n <= 1'b1;
    end else if (verify_sel && !lock_bit_two) begin
      link.dev_data <= ~(code_byte ^ enc_mem[{1'b0, addr[`ENC_SEL_BITS-1:0]}]);
      link.dev_data_oe_n <= 1'b0;
    end else if (sig_sel) begin
      link.dev_data <= sig_lookup(pins.low_address);
      link.dev_data_oe_n <= 1'b0;
    end else begin
      link.dev_data <= 8'hff;
      link.dev_data_oe_n <= 1'b1;
    end
  end

  // Protection outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_read_blocked <= 1'b0;
      ext_exec_blocked <= 1'b0;
      ext_access_latched <= 1'b0;
    end else begin
      table_read_blocked <= lock_bit_one;
      ext_exec_blocked <= lock_bit_one && lock_bit_two && lock_bit_three;
      if (pins.reset_pin && lock_bit_one) ext_access_latched <= pins.supply_level;
    end
  end
endmodule // otp_device

/* File: otp_link_monitor.sv */
// Concurrent checks on the programming link between the two ends.
// Assumes it sits in the bench beside the link interface.
`include "otp_port_consts.svh"
module otp_link_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link levels
  input wire logic osc_clk,
  input wire logic reset_pin,
  input wire logic fetch_strobe,
  input wire logic program_strobe,
  input wire logic supply_vpp,
  input wire logic mode_select_a,
  input wire logic mode_select_b,
  input wire logic mode_select_c,
  input wire logic mode_select_d,
  input wire logic mode_select_e,
  input wire logic [7:0] low_address_port,
  input wire logic [4:0] high_address_port,
  input wire logic [7:0] prog_data,
  input wire logic prog_data_oe_n,
  input wire logic dev_data_oe_n
);
  logic [4:0] modes;
  logic [7:0] pulse_cnt;
  assign modes = {mode_select_a, mode_select_b, mode_select_c, mode_select_d, mode_select_e};
  default clocking mon_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Strobe falls counted since the supply was raised
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt <= 8'h00;
    end else if ($rose(supply_vpp)) begin
      pulse_cnt <= 8'h00;
    end else if ($fell(program_strobe)) begin
      pulse_cnt <= pulse_cnt + 8'h01;
    end
  end
  a_pulse_needs_vpp: assert property ($fell(program_strobe) |-> supply_vpp && !reset_pin && !fetch_strobe)
    else $error("strobe pulse outside a programming mode");
  a_vpp_before_pulse: assert property ($rose(supply_vpp) |-> program_strobe [*8])
    else $error("supply raised during a strobe pulse");
  a_vpp_after_pulse: assert property ($fell(supply_vpp) |-> program_strobe && $past(program_strobe, 100))
    else $error("supply lowered too close to a pulse");
  a_pulse_count: assert property ($fell(supply_vpp) |-> pulse_cnt == ((modes == `MODE_CODE) ? 8'h05 : 8'h19))
    else $error("wrong number of strobe pulses");
  a_levels_held: assert property (!program_strobe |-> $stable({high_address_port, low_address_port, prog_data, modes}))
    else $error("address, data or mode moved during a pulse");
  a_setup_order: assert property ($rose(supply_vpp) |-> modes == $past(modes, 100) && !$past(reset_pin, 100))
    else $error("modes not set well before the supply rose");
  a_no_data_fight: assert property (prog_data_oe_n || dev_data_oe_n)
    else $error("both ends drive the data port");
  a_drive_on_read: assert property ($fell(dev_data_oe_n) |-> !reset_pin && !supply_vpp && program_strobe
    && (modes == `MODE_VERIFY || modes == `MODE_SIG))
    else $error("device drives data outside a read mode");
  a_verify_levels: assert property (!reset_pin && modes == `MODE_VERIFY |-> !fetch_strobe && !supply_vpp && program_strobe)
    else $error("bad control levels in verify");
  a_sig_levels: assert property (!reset_pin && modes == `MODE_SIG |-> fetch_strobe && !supply_vpp && program_strobe)
    else $error("bad control levels in signature read");
  a_osc_running: assert property (!reset_pin && !$past(reset_pin, 2) |-> osc_clk != $past(osc_clk, 2))
    else $error("oscillator stalled while in a mode");
endmodule // otp_link_monitor

/* File: tb.sv */
// Self-checking bench: programmer and device joined by the link.
// Assumes a 20 MHz ref_clk; the run takes about 70k cycles.
`include "otp_port_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import otp_port_pkg::*;
  localparam logic [7:0] SIG0 = 8'h5a; // Arbitrary value
  localparam logic [7:0] SIG1 = 8'ha5; // Arbitrary value
  localparam logic [7:0] SIG2 = 8'hc3; // Arbitrary value
  logic ref_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic table_read_blocked;
  logic ext_exec_blocked;
  logic ext_access_latched;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] q;

  otp_link_if link ();
  otp_programmer u_otp_programmer (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link.programmer));
  otp_device #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) u_otp_device (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link.device), .table_read_blocked(table_read_blocked),
    .ext_exec_blocked(ext_exec_blocked), .ext_access_latched(ext_access_latched));
  otp_link_monitor u_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .osc_clk(link.osc_clk),
    .reset_pin(link.reset_pin), .fetch_strobe(link.fetch_strobe), .program_strobe(link.program_strobe),
    .supply_vpp(link.supply_vpp), .mode_select_a(link.mode_select_a), .mode_select_b(link.mode_select_b),
    .mode_select_c(link.mode_select_c), .mode_select_d(link.mode_select_d), .mode_select_e(link.mode_select_e),
    .low_address_port(link.low_address_port), .high_address_port(link.high_address_port),
    .prog_data(link.prog_data), .prog_data_oe_n(link.prog_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n));

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic start(input prog_op_e op, input logic [12:0] a, input logic [7:0] d);
    wr(`REG_ADDR, {3'h0, a});
    wr(`REG_DATA, {8'h00, d});
    wr(`REG_CTRL, {8'h00, 1'h1, 4'h0, op});
  endtask

  task automatic finish(output logic [7:0] r);
    logic [15:0] st;
    int n;
    n = 0;
    st = 16'h0001;
    while (st[0] !== 1'h0 && n < 30000) begin
      rd(`REG_STATUS, st);
      n++;
    end
    check({14'h0000, st[1:0]}, 16'h0002, "status");
    rd(`REG_RDATA, st);
    r = st[7:0];
  endtask

  task automatic run(input prog_op_e op, input logic [12:0] a, input logic [7:0] d, output logic [7:0] r);
    start(op, a, d);
    finish(r);
  endtask

  task automatic t_idle;
    logic [15:0] v;
    @(negedge ref_clk);
    check({8'h00, link.reset_pin, link.fetch_strobe, link.program_strobe, link.supply_vpp, link.dev_data_oe_n,
      table_read_blocked, ext_exec_blocked, ext_access_latched}, 16'h00e8, "idle levels");
    rd(8'h20, v);
    check(v, 16'h0000, "unmapped read");
  endtask

  task automatic t_blank;
    run(op_verify, 13'h1fff, 8'h00, q);
    check({8'h00, q}, 16'h00ff, "blank verify");
  endtask

  task automatic t_code;
    start(op_code, 13'h1005, 8'ha6);
    wr(`REG_ADDR, 16'h0005);
    wr(`REG_CTRL, {8'h00, 1'h1, 4'h0, op_verify});
    finish(q);
    run(op_verify, 13'h1005, 8'h00, q);
    check({8'h00, q}, 16'h00a6, "code verify");
    run(op_verify, 13'h0005, 8'h00, q);
    check({8'h00, q}, 16'h00ff, "high address");
  endtask

  task automatic t_enc;
    logic [7:0] e;
    e = 8'h3c;
    run(op_enc, 13'h0005, e, q);
    run(op_verify, 13'h1005, 8'h00, q);
    check({8'h00, q}, {8'h00, ~(8'ha6 ^ e)}, "scrambled verify");
    run(op_verify, 13'h0025, 8'h00, q);
    check({8'h00, q}, {8'h00, e}, "index wraps");
    run(op_verify, 13'h1fff, 8'h00, q);
    check({8'h00, q}, 16'h00ff, "unprogrammed index");
    check({15'h0000, table_read_blocked}, 16'h0000, "no lock");
  endtask

  task automatic t_sig;
    logic [7:0] loc [4] = '{8'h30, 8'h31, 8'h60, 8'h32};
    logic [7:0] exp [4] = '{SIG0, SIG1, SIG2, 8'h00};
    for (int i = 0; i < 4; i++) begin
      run(op_sig, {5'h00, loc[i]}, 8'h00, q);
      check({8'h00, q}, {8'h00, exp[i]}, "signature");
    end
  endtask

  task automatic t_lock;
    int n;
    n = 0;
    start(op_lock1, 13'h0000, 8'hff);
    while (table_read_blocked !== 1'h1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, table_read_blocked}, 16'h0001, "lock one");
    check({15'h0000, ext_exec_blocked}, 16'h0000, "lock one alone");
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(negedge ref_clk);
    check({15'h0000, table_read_blocked}, 16'h0000, "lock cleared by reset");
    run(op_verify, 13'h1005, 8'h00, q);
    check({8'h00, q}, 16'h00ff, "blank after reset");
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      test_done;
    end
  end

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    rst_n = 1'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_idle;
    t_blank;
    t_code;
    t_enc;
    t_sig;
    t_lock;
    test_done;
  end
endmodule // tb
